// ---- src/hs_irq_pkg.sv ----
package hs_irq_pkg;

	// ************************************************************
	// register map, byte addresses on the avalon slave
	// ************************************************************
	localparam logic [5:0] CFG_OFFSET = 6'h10;
	localparam logic [5:0] CTRL_OFFSET = 6'h20;
	localparam logic [5:0] STATUS_OFFSET = 6'h24;
	localparam logic [5:0] MASK_OFFSET = 6'h28;

	// ************************************************************
	// configuration fields and reset values
	// ************************************************************
	localparam int CTRL_FILT_MSB = 7;
	localparam int CTRL_FILT_LSB = 6;
	localparam int IN_FILT_MSB = 5;
	localparam int IN_FILT_LSB = 4;
	localparam int OUT_FILT_MSB = 3;
	localparam int OUT_FILT_LSB = 2;
	localparam int PULSE_SEL_BIT = 1;
	localparam int ACTIVE_HIGH_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'hFC;
	localparam logic [5:0] FILT_BUS_RESET = 6'h3F;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// filter encodings; bit 1 set means first nak only
	localparam logic [1:0] FILT_ALL = 2'h0;
	localparam logic [1:0] FILT_ACK_ONLY = 2'h1;

	// status bit positions, one per endpoint group
	localparam int GRP_CTRL = 0;
	localparam int GRP_IN = 1;
	localparam int GRP_OUT = 2;
	localparam int NUM_GRP = 3;

	// ************************************************************
	// handshake kinds reported by the serial interface engine
	// ************************************************************
	typedef enum logic [1:0]
	{
		HS_ACK,
		HS_NAK,
		HS_NYET,
		HS_STALL
	} handshake_t;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ = 20;
	localparam int PULSE_NS = 60;
	// least time, rounded up to whole cycles
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;

endpackage : hs_irq_pkg

// ---- src/irq_pulse_gen.sv ----
`timescale 1ns/1ps

module irq_pulse_gen
#(
	parameter int LEN = 2
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// trigger and pulse
	input wire logic fire,
	output logic pulse
);

	logic [7:0] cnt_r;
	logic pulse_r;

	// one fixed-length pulse per trigger; a trigger inside a pulse restarts it
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r <= 8'h00;
			pulse_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (fire)
			begin
				cnt_r <= 8'(LEN - 1);
				pulse_r <= 1'b1;
			end
			else if (cnt_r != 8'h00)
			begin
				cnt_r <= cnt_r - 8'h01;
			end
			else
			begin
				pulse_r <= 1'b0;
			end
		end
	end

	assign pulse = pulse_r;

endmodule : irq_pulse_gen

// ---- src/usb_handshake_interrupt_config.sv ----
`timescale 1ns/1ps

// What this block does
// - eight-bit interrupt configuration register at 10h
// - ack, nak, nyet handshakes raise candidate events
// - bits 7:6 ep0, 5:4 in, 3:2 out
// - ctrl/in: 00 ack+nak, 01 ack, 1x first nak
// - out: 00 all, 01 ack+nyet, 1x first nak
// - first nak follows completed setup and ack
// - bit 1 selects level or two-cycle (100 ns) pulse
// - bit 0 selects active low or high
// - in pulse mode polarity picks edge direction
// - hw reset fc; bus reset sets filters only
// - global enable gates pin; pulse drops old events
// - route ep0, in and out to their filters
module usb_handshake_interrupt_config
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// handshake reports from the serial interface engine
	input wire logic hs_valid,
	input wire hs_irq_pkg::handshake_t hs_kind,
	input wire logic [3:0] hs_endpoint,
	input wire logic hs_dir_in,
	input wire logic setup_acked,
	input wire logic usb_bus_reset,
	// interrupt outputs
	output logic irq_pin,
	output logic irq
);
	import hs_irq_pkg::*;

	logic [7:0] cfg_r;
	logic irq_global_enable_r;
	logic [NUM_GRP-1:0] status_r;
	logic [NUM_GRP-1:0] mask_r;
	logic [NUM_GRP-1:0] armed_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic irq_pin_r;
	logic irq_active;
	logic [1:0] filt [NUM_GRP];
	logic [NUM_GRP-1:0] grp_hit;
	logic [NUM_GRP-1:0] evt;
	logic [NUM_GRP-1:0] pending;
	logic fire;
	logic pulse;
	logic bus_done;
	logic wr_cfg;
	logic rd_status;

	// ************************************************************
	// avalon slave handshake
	// ************************************************************

	// one wait cycle, then the answer; ack_r drops at the accepting edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign bus_done = (avs_read || avs_write) && ack_r;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_r <= 1'b0;
		end
		else if (clk_en)
		begin
			ack_r <= (avs_read || avs_write) && !ack_r;
		end
	end

	// read data captured in the wait cycle, stable at the accepting edge
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata_r <= 32'h0000_0000;
		end
		else if (clk_en && avs_read && !ack_r)
		begin
			if (avs_address == CFG_OFFSET)
				rdata_r <= {24'h00_0000, cfg_r};
			else if (avs_address == CTRL_OFFSET)
				rdata_r <= {31'h0000_0000, irq_global_enable_r};
			else if (avs_address == STATUS_OFFSET)
				rdata_r <= {29'h0000_0000, status_r};
			else if (avs_address == MASK_OFFSET)
				rdata_r <= {29'h0000_0000, mask_r};
			else
				rdata_r <= 32'h0000_0000;
		end
	end

	assign avs_readdata = rdata_r;
	// only byte lane 0 carries register bits
	assign wr_cfg = bus_done && avs_write && avs_byteenable[0] && avs_address == CFG_OFFSET;
	assign rd_status = bus_done && avs_read && avs_address == STATUS_OFFSET;

	// ************************************************************
	// configuration register
	// ************************************************************

	// bus reset outranks a write landing in the same cycle
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_r <= CFG_RESET;
		end
		else if (clk_en)
		begin
			if (usb_bus_reset)
				cfg_r <= {FILT_BUS_RESET, cfg_r[PULSE_SEL_BIT:ACTIVE_HIGH_BIT]};
			else if (wr_cfg)
				cfg_r <= avs_writedata[7:0];
		end
	end

	// global enable and mask
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_global_enable_r <= 1'b0;
			mask_r <= MASK_RESET;
		end
		else if (clk_en && bus_done && avs_write && avs_byteenable[0])
		begin
			if (avs_address == CTRL_OFFSET)
				irq_global_enable_r <= avs_writedata[0];
			else if (avs_address == MASK_OFFSET)
				mask_r <= avs_writedata[NUM_GRP-1:0];
		end
	end

	// ************************************************************
	// handshake qualification per endpoint group
	// ************************************************************

	assign filt[GRP_CTRL] = cfg_r[CTRL_FILT_MSB:CTRL_FILT_LSB];
	assign filt[GRP_IN] = cfg_r[IN_FILT_MSB:IN_FILT_LSB];
	assign filt[GRP_OUT] = cfg_r[OUT_FILT_MSB:OUT_FILT_LSB];

	// ep0 in, out and setup all go to the control group
	assign grp_hit[GRP_CTRL] = hs_valid && hs_endpoint == 4'h0;
	assign grp_hit[GRP_IN] = hs_valid && hs_endpoint != 4'h0 && hs_dir_in;
	assign grp_hit[GRP_OUT] = hs_valid && hs_endpoint != 4'h0 && !hs_dir_in;

	genvar g;
	generate
		for (g = 0; g < NUM_GRP; g++)
		begin : grp
			logic nak_ok;
			logic nyet_ok;

			// nak passes on all-mode, or once after a setup in first-nak mode
			assign nak_ok = filt[g] == FILT_ALL || (filt[g][1] && armed_r[g]);
			// nyet only exists on the out group, and no filter setting hides it
			assign nyet_ok = g == GRP_OUT;
			assign evt[g] = grp_hit[g] && (hs_kind == HS_ACK
				|| (hs_kind == HS_NAK && nak_ok)
				|| (hs_kind == HS_NYET && nyet_ok));

			// armed by a completed setup stage; setup wins over a same-cycle nak
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
				begin
					armed_r[g] <= 1'b0;
				end
				else if (clk_en)
				begin
					if (setup_acked)
						armed_r[g] <= 1'b1;
					else if (grp_hit[g] && hs_kind == HS_NAK)
						armed_r[g] <= 1'b0;
				end
			end

			// sticky status; a new event beats the read, and only bits the read returned are cleared,
			// so an event landing in the read's wait cycle is not lost
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
				begin
					status_r[g] <= 1'b0;
				end
				else if (clk_en)
				begin
					if (evt[g])
						status_r[g] <= 1'b1;
					else if (rd_status && rdata_r[g])
						status_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ************************************************************
	// interrupt signalling
	// ************************************************************

	assign pending = status_r & mask_r;
	assign irq = |pending;

	// pulse mode fires only on events seen while enabled, so older ones are lost
	assign fire = |(evt & mask_r) && irq_global_enable_r && cfg_r[PULSE_SEL_BIT];

	irq_pulse_gen #(
		.LEN(PULSE_CYC)
	) u_pulse (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.fire(fire),
		.pulse(pulse)
	);

	// level: pending and enabled; pulse: fixed-width strobe
	always_comb
	begin
		if (cfg_r[PULSE_SEL_BIT])
			irq_active = pulse;
		else
			irq_active = (|pending) && irq_global_enable_r;
	end

	// pin registered so the strobe width is glitch free; reset shows inactive low-true
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_pin_r <= 1'b1;
		end
		else if (clk_en)
		begin
			irq_pin_r <= irq_active ~^ cfg_r[ACTIVE_HIGH_BIT];
		end
	end

	assign irq_pin = irq_pin_r;

	// ************************************************************
	// assertions
	// ************************************************************

	property p_cfg_write;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && wr_cfg && !usb_bus_reset |=> cfg_r == $past(avs_writedata[7:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

	property p_bus_reset;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && usb_bus_reset |=> cfg_r[7:2] == 6'h3F && cfg_r[1:0] == $past(cfg_r[1:0]);
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("bus reset value wrong");

	property p_ep0_ack;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && hs_valid && hs_kind == HS_ACK && hs_endpoint == 4'h0 |=> status_r[GRP_CTRL];
	endproperty
	a_ep0_ack: assert property (p_ep0_ack) else $error("ep0 ack not flagged");

	property p_in_ack_only;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && grp_hit[GRP_IN] && hs_kind == HS_NAK && filt[GRP_IN] == FILT_ACK_ONLY
			&& !status_r[GRP_IN] |=> !status_r[GRP_IN];
	endproperty
	a_in_ack_only: assert property (p_in_ack_only) else $error("in nak passed ack-only filter");

	property p_out_nyet;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && grp_hit[GRP_OUT] && hs_kind == HS_NYET |=> status_r[GRP_OUT];
	endproperty
	a_out_nyet: assert property (p_out_nyet) else $error("out nyet not flagged");

	sequence s_setup_then_nak;
		setup_acked && clk_en ##1 (grp_hit[GRP_OUT] && hs_kind == HS_NAK && filt[GRP_OUT][1] && clk_en
			&& !setup_acked);
	endsequence
	property p_first_nak;
		@(posedge clk_sys) disable iff (!rst_b)
		s_setup_then_nak |=> status_r[GRP_OUT] && !armed_r[GRP_OUT];
	endproperty
	a_first_nak: assert property (p_first_nak) else $error("first nak handling wrong");

	sequence s_pulse_start;
		clk_en && fire;
	endsequence
	property p_pulse_len;
		@(posedge clk_sys) disable iff (!rst_b)
		s_pulse_start ##1 (clk_en && !fire) [*2] |=> !pulse;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse width wrong");

	property p_pulse_pin;
		@(posedge clk_sys) disable iff (!rst_b)
		s_pulse_start ##1 (clk_en && cfg_r[PULSE_SEL_BIT]) |=> irq_pin == $past(cfg_r[ACTIVE_HIGH_BIT]);
	endproperty
	a_pulse_pin: assert property (p_pulse_pin) else $error("pulse edge direction wrong");

	property p_no_new_pulse;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !irq_global_enable_r && !pulse |=> !pulse;
	endproperty
	a_no_new_pulse: assert property (p_no_new_pulse) else $error("pulse started while disabled");

	property p_polarity;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en |=> irq_pin == ($past(irq_active) ~^ $past(cfg_r[0]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

	property p_global_gate;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !irq_global_enable_r && !cfg_r[1] |=> irq_pin == !$past(cfg_r[0]);
	endproperty
	a_global_gate: assert property (p_global_gate) else $error("pin active while disabled");

	property p_level_hold;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !cfg_r[1] && irq_global_enable_r && (|pending) |=> irq_pin == $past(cfg_r[0]);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level dropped while pending");

	property p_read_clear;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && rd_status && evt == '0 && status_r == rdata_r[NUM_GRP-1:0] |=> status_r == '0;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

	property p_one_wait;
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");

endmodule : usb_handshake_interrupt_config

// ---- bench/irq_receiver.sv ----
`timescale 1ns/1ps

// ****
// host-side interrupt input
// ****
module irq_receiver
(
	// pin and the polarity the host expects
	input wire logic irq_pin,
	input wire logic active_high
);
	int edges = 0;
	realtime t_on = 0;
	realtime width = 0;
	logic act;

	// a polarity change can look like an edge, so users take deltas
	assign act = active_high ? irq_pin : !irq_pin;

	// count assertions, time the last one
	always @(posedge act)
	begin
		edges++;
		t_on = $realtime;
	end
	always @(negedge act)
		width = $realtime - t_on;
endmodule : irq_receiver

// ---- bench/tb_usb_handshake_interrupt_config.sv ----
`timescale 1ns/1ps

module tb_usb_handshake_interrupt_config;
	import hs_irq_pkg::*;
	typedef struct packed
	{
		logic [7:0] cfg;
		logic stp;
		handshake_t k;
		logic [3:0] ep;
		logic din;
		logic [2:0] st;
	} row_t;
	logic clk_sys = 0, rst_b = 0, avs_read = 0, avs_write = 0, hs_valid = 0, hs_dir_in = 0;
	logic setup_acked = 0, usb_bus_reset = 0, rx_pol = 0, clk_en = 1, avs_waitrequest, irq_pin, irq;
	logic [5:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, q;
	logic [3:0] hs_endpoint = 0, avs_byteenable = 4'hF;
	handshake_t hs_kind = HS_ACK;
	int errors = 0, checks = 0, e0;
	row_t rows [17] = '{'{8'h00,1'h0,HS_ACK,4'h0,1'h0,3'h1}, '{8'h00,1'h0,HS_NAK,4'h0,1'h0,3'h1},
		'{8'h00,1'h0,HS_NAK,4'h2,1'h1,3'h2}, '{8'h00,1'h0,HS_NYET,4'h3,1'h0,3'h4},
		'{8'h00,1'h0,HS_NYET,4'h0,1'h0,3'h0}, '{8'h00,1'h0,HS_NYET,4'h5,1'h1,3'h0},
		'{8'h00,1'h0,HS_STALL,4'h1,1'h0,3'h0}, '{8'h54,1'h0,HS_NAK,4'h0,1'h0,3'h0},
		'{8'h54,1'h0,HS_NAK,4'h4,1'h1,3'h0}, '{8'h54,1'h0,HS_NAK,4'h6,1'h0,3'h0},
		'{8'h54,1'h0,HS_NYET,4'h6,1'h0,3'h4}, '{8'h54,1'h0,HS_ACK,4'h7,1'h1,3'h2},
		'{8'hFC,1'h1,HS_NAK,4'h1,1'h1,3'h2}, '{8'hFC,1'h0,HS_NAK,4'h1,1'h1,3'h0},
		'{8'hFC,1'h0,HS_NAK,4'h0,1'h1,3'h1}, '{8'hFC,1'h0,HS_ACK,4'h2,1'h0,3'h4},
		'{8'hA8,1'h1,HS_NAK,4'h3,1'h0,3'h4}};

	usb_handshake_interrupt_config uut
	(
		.clk_sys, .rst_b, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .hs_valid, .hs_kind, .hs_endpoint,
		.hs_dir_in, .setup_acked, .usb_bus_reset, .irq_pin, .irq
	);
	irq_receiver rx
	(
		.irq_pin(irq_pin),
		.active_high(rx_pol)
	);

	// 20 mhz system clock
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// one avalon access, held until waitrequest is seen low; bounded so a hang ends the run
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		// sampled at the rising edge, where flops still show their pre-edge values
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'h0 && n < 50);
		if (n >= 50)
		begin
			errors++;
			final_report();
		end
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask : bus

	// one handshake report, optionally after a setup-ack pulse; returns with level pin settled
	task automatic hs(input logic stp, input handshake_t k, input logic [3:0] ep, input logic din);
		@(posedge clk_sys);
		// setup ack directly before the handshake, so the nak is the first one after it
		if (stp)
		begin
			setup_acked <= 1'h1;
			@(posedge clk_sys);
		end
		setup_acked <= 1'h0;
		hs_kind <= k;
		hs_endpoint <= ep;
		hs_dir_in <= din;
		hs_valid <= 1'h1;
		@(posedge clk_sys);
		hs_valid <= 1'h0;
		repeat (2) @(negedge clk_sys);
	endtask : hs

	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'h1;
		// ****
		// reset state
		// ****
		bus(0, CFG_OFFSET, 8'h00);
		chk("cfg", q, 32'h0000_00FC);
		bus(0, 6'h3C, 8'h00);
		chk("unmapped", q, 32'h0000_0000);
		chk("idle pin", irq_pin, 32'h1);
		bus(1, MASK_OFFSET, 8'h07);
		bus(1, CTRL_OFFSET, 8'h01);
		// ****
		// filter table, level active low
		// ****
		foreach (rows[i])
		begin
			bus(1, CFG_OFFSET, rows[i].cfg);
			hs(rows[i].stp, rows[i].k, rows[i].ep, rows[i].din);
			chk("pin", irq_pin, rows[i].st == 3'h0);
			bus(0, STATUS_OFFSET, 8'h00);
			chk("status", q, rows[i].st);
			repeat (2) @(negedge clk_sys);
			chk("released pin", irq_pin, 32'h1);
		end
		// masked event stays off, then shows when unmasked
		bus(1, MASK_OFFSET, 8'h00);
		hs(0, HS_ACK, 4'h0, 0);
		chk("masked irq", irq, 32'h0);
		chk("masked pin", irq_pin, 32'h1);
		bus(1, MASK_OFFSET, 8'h01);
		repeat (2) @(negedge clk_sys);
		chk("unmasked irq", irq, 32'h1);
		chk("unmasked pin", irq_pin, 32'h0);
		// global enable holds off a pending event, then it shows at once
		bus(1, CTRL_OFFSET, 8'h00);
		repeat (2) @(negedge clk_sys);
		chk("disabled pin", irq_pin, 32'h1);
		bus(1, CTRL_OFFSET, 8'h01);
		repeat (2) @(negedge clk_sys);
		chk("enabled pin", irq_pin, 32'h0);
		bus(0, STATUS_OFFSET, 8'h00);
		bus(1, MASK_OFFSET, 8'h07);
		// level active high
		bus(1, CFG_OFFSET, 8'h01);
		repeat (2) @(negedge clk_sys);
		chk("high idle", irq_pin, 32'h0);
		hs(0, HS_ACK, 4'h0, 0);
		chk("high active", irq_pin, 32'h1);
		bus(0, STATUS_OFFSET, 8'h00);
		// ****
		// pulse mode, both polarities, then with enable off
		// ****
		for (int p = 1; p >= 0; p--)
		begin
			rx_pol <= p[0];
			bus(1, CFG_OFFSET, {7'h01, p[0]});
			repeat (2) @(negedge clk_sys);
			e0 = rx.edges;
			hs(0, HS_ACK, 4'h0, 0);
			repeat (3) @(negedge clk_sys);
			chk("pulses", rx.edges - e0, 32'h1);
			chk("pulse width", rx.width >= 60.0, 32'h1);
			chk("pulse idle", irq_pin, !p[0]);
		end
		bus(1, CTRL_OFFSET, 8'h00);
		e0 = rx.edges;
		hs(0, HS_ACK, 4'h0, 0);
		bus(1, CTRL_OFFSET, 8'h01);
		repeat (4) @(negedge clk_sys);
		chk("dropped pulses", rx.edges - e0, 32'h0);
		// ****
		// bus reset keeps mode bits, hardware reset clears them
		// ****
		@(posedge clk_sys);
		usb_bus_reset <= 1'h1;
		@(posedge clk_sys);
		usb_bus_reset <= 1'h0;
		bus(0, CFG_OFFSET, 8'h00);
		chk("cfg after bus reset", q, 32'h0000_00FE);
		// lane 0 off: the write must not land
		avs_byteenable <= 4'hE;
		bus(1, CFG_OFFSET, 8'h00);
		avs_byteenable <= 4'hF;
		bus(0, CFG_OFFSET, 8'h00);
		chk("lane 0 off", q, 32'h0000_00FE);
		// a frozen clock enable ignores a handshake
		bus(0, STATUS_OFFSET, 8'h00);
		clk_en <= 1'h0;
		hs(0, HS_ACK, 4'h0, 0);
		@(posedge clk_sys);
		clk_en <= 1'h1;
		bus(0, STATUS_OFFSET, 8'h00);
		chk("frozen status", q, 32'h0000_0000);
		@(posedge clk_sys);
		rst_b <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'h1;
		bus(0, CFG_OFFSET, 8'h00);
		chk("cfg after reset", q, 32'h0000_00FC);
		chk("pin after reset", irq_pin, 32'h1);
		final_report();
	end
endmodule : tb_usb_handshake_interrupt_config
